// *** src/rsq_sequencer.sv ***
// rail on/off sequencer: delays, ramps, timeouts, hold-low and retry timing
// Operation
// R01 - wait turn_on_delay, zero still 270 us
// R02 - rise ramp 0..1.3 s in 0.1 ms steps
// R03 - force discontinuous mode during rise ramp
// R04 - rise below 0.25 ms applies setpoint directly
// R05 - flag rise timeout, zero disables, 83 s max
// R06 - setpoint changes slew, capped at 4 V/ms
// R07 - wait turn_off_delay before fall ramp
// R08 - fault shutdown skips turn_off_delay
// R09 - ramp reference to zero, then switch output off
// R10 - fall ramp 0.25 ms..1.3 s, 0.1 ms steps
// R11 - warn if decay above 12.5% too long
// R12 - decay limit zero disables, else 120 ms..524 s
// R13 - on enable falling edge hold pin low
// R14 - hold 136 ms..65.52 s in 16 ms steps
// R15 - host sizes hold above off delay plus fall
// R16 - decay option keeps output off until decayed
// R17 - one retry interval, timed from fault detection
// R18 - retry interval 120 ms..83.88 s, 1 ms steps
// R19 - retry waits longer of interval and decay; code waits for decay only when decay_wait_en is clear
// R20 - input overvoltage sets three flags and alert
// R21 - host should pick continuous mode for fall
// R22 - discontinuous mode never sinks load current
// R23 - start request is enable pin and power state
// R24 - mask undervoltage unless channel fully on
// R25 - timers run from common tick, reset when off
`timescale 1ns/100ps
`include "rsq_consts.svh"

module rsq_sequencer #(
	parameter int TICK_CYCLES = `RSQ_TICK_CYCLES,
	parameter int DAC_CODES_PER_V = 500
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	input wire logic power_state_on,
	input wire logic rail_enable_in,
	output logic rail_enable_out,
	output logic rail_enable_oe,
	input wire logic [11:0] output_setpoint,
	input wire logic ccm_mode,
	input wire logic decay_wait_en,
	input wire logic vout_above_uv,
	input wire logic oc_limit_hit,
	input wire logic vout_above_decay,
	input wire logic fault_shutdown,
	input wire logic fault_retry,
	input wire logic vin_ov_fault,
	input wire logic alert_mask,
	output logic [11:0] ref_dac,
	output logic pwm_hiz,
	output logic force_dcm,
	output logic sink_enable,
	output logic uv_mask,
	output logic channel_on,
	output logic rise_timeout_fault,
	output logic decay_warn,
	output logic alert_n
);
	localparam logic [12:0][15:0] RESET_REGS = {`RSQ_RST_SLEW, `RSQ_RST_TMO_LIM,
		`RSQ_RST_RISE, `RSQ_RST_ON_DLY, `RSQ_RST_HOLD, `RSQ_RST_RETRY, `RSQ_RST_DECAY,
		`RSQ_RST_FALL, `RSQ_RST_OFF_DLY, `RSQ_RST_TMO_ACT, `RSQ_RST_VIN_ACT,
		`RSQ_RST_UV_ACT, `RSQ_RST_OV_ACT};
	localparam logic [12:0] TICK_LAST = 13'(TICK_CYCLES - 1);
	localparam logic [23:0] MAX_DELAY_TICKS = 24'(`RSQ_DELAY_MAX_MS * `RSQ_TICKS_PER_MS);
	localparam logic [23:0] MAX_RAMP_STEPS = 24'(`RSQ_RAMP_MAX_MS * `RSQ_TICKS_PER_MS);
	localparam logic [23:0] MAX_SLEW = 24'(`RSQ_SLEW_MAX_V_PER_MS * DAC_CODES_PER_V);

	// linear 5s/11s value times mult; negative mantissa reads as zero
	function automatic logic [23:0] rsq_l11(input logic [15:0] v, input logic [15:0] mult);
		logic [31:0] p;
		p = 32'(v[10:0]) * 32'(mult);
		if (v[10]) begin
			p = 32'h0;
		end else if (v[15]) begin
			p = p >> (6'h20 - {1'b0, v[15:11]});
		end else if (v[15:11] > 5'h08) begin
			p = 32'hffffffff;
		end else begin
			p = p << v[15:11];
		end
		return (p > 32'h00ffffff) ? 24'hffffff : p[23:0];
	endfunction

	function automatic logic [23:0] rsq_clamp(input logic [23:0] v, input logic [23:0] lo,
			input logic [23:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// a * k / n, the share of a reached after k of n steps
	function automatic logic [11:0] rsq_ramp(input logic [11:0] a, input logic [23:0] k,
			input logic [23:0] n);
		logic [35:0] p;
		p = 36'(a) * 36'(k);
		if (n == 24'h0 || k >= n) begin
			return a;
		end
		return 12'(p / 36'(n));
	endfunction

	function automatic logic [3:0] rsq_index(input logic [7:0] code);
		unique case (code)
			`RSQ_CMD_OV_ACT: return 4'h0;
			`RSQ_CMD_UV_ACT: return 4'h1;
			`RSQ_CMD_VIN_ACT: return 4'h2;
			`RSQ_CMD_TMO_ACT: return 4'h3;
			`RSQ_CMD_OFF_DLY: return 4'h4;
			`RSQ_CMD_FALL: return 4'h5;
			`RSQ_CMD_DECAY: return 4'h6;
			`RSQ_CMD_RETRY: return 4'h7;
			`RSQ_CMD_HOLD: return 4'h8;
			`RSQ_CMD_ON_DLY: return 4'h9;
			`RSQ_CMD_RISE: return 4'ha;
			`RSQ_CMD_TMO_LIM: return 4'hb;
			`RSQ_CMD_SLEW: return 4'hc;
			default: return 4'hf;
		endcase
	endfunction

	function automatic logic rsq_retries(input logic [15:0] act);
		return act[`RSQ_ACT_RETRY_MSB:`RSQ_ACT_RETRY_LSB] == `RSQ_ACT_RETRY_ALWAYS;
	endfunction

	rsq_pkg::rsq_state_type s;
	rsq_pkg::rsq_state_type n;
	logic tick;
	logic tick_ms;
	logic start_req;
	logic pin_fall;
	logic tmo_hit;
	logic fault_now;
	logic retry_now;
	logic rise_bypass;
	logic [3:0] wr_idx;
	logic [23:0] on_dly;
	logic [23:0] off_dly;
	logic [23:0] rise_steps;
	logic [23:0] fall_steps;
	logic [23:0] tmo_ms;
	logic [23:0] decay_ms;
	logic [23:0] hold_ms;
	logic [23:0] retry_ms;
	logic [23:0] slew_step;
	logic [11:0] slew_diff;

	// zero delay still costs the fixed start latency
	assign on_dly = rsq_clamp(rsq_l11(s.regs[9], 16'(`RSQ_TICKS_PER_MS)),
		24'(`RSQ_ZERO_LAT_TICKS), MAX_DELAY_TICKS); // R01
	assign off_dly = rsq_clamp(rsq_l11(s.regs[4], 16'(`RSQ_TICKS_PER_MS)),
		24'(`RSQ_ZERO_LAT_TICKS), MAX_DELAY_TICKS); // R07
	assign rise_steps = rsq_clamp(rsq_l11(s.regs[10], 16'(`RSQ_TICKS_PER_MS)),
		24'h0, MAX_RAMP_STEPS); // R02
	assign rise_bypass = rsq_l11(s.regs[10], 16'h0064) < 24'(`RSQ_RISE_BYPASS_CENTI_MS); // R04
	assign fall_steps = rsq_clamp(rsq_l11(s.regs[5], 16'(`RSQ_TICKS_PER_MS)),
		24'(`RSQ_FALL_MIN_STEPS), MAX_RAMP_STEPS); // R10
	assign tmo_ms = rsq_clamp(rsq_l11(s.regs[11], 16'h0001), 24'h0,
		24'(`RSQ_DELAY_MAX_MS)); // R05
	assign decay_ms = (rsq_l11(s.regs[6], 16'h0001) == 24'h0) ? 24'h0 :
		rsq_clamp(rsq_l11(s.regs[6], 16'h0001), 24'(`RSQ_DECAY_MIN_MS),
		24'(`RSQ_DECAY_MAX_MS)); // R12
	// hold rounds down to the 16 ms grain
	assign hold_ms = rsq_clamp(rsq_l11(s.regs[8], 16'h0001) & ~24'(`RSQ_HOLD_RES_MS - 1),
		24'(`RSQ_HOLD_MIN_MS), 24'(`RSQ_HOLD_MAX_MS)); // R14
	assign retry_ms = rsq_clamp(rsq_l11(s.regs[7], 16'h0001), 24'(`RSQ_RETRY_MIN_MS),
		24'(`RSQ_RETRY_MAX_MS)); // R18
	assign slew_step = rsq_clamp(rsq_l11(s.regs[12], 16'(DAC_CODES_PER_V)), 24'(10),
		MAX_SLEW) / 24'(`RSQ_TICKS_PER_MS); // R06

	assign tick = s.div == TICK_LAST; // R25
	assign tick_ms = tick && s.msdiv == 4'(`RSQ_TICKS_PER_MS - 1); // R25
	assign start_req = rail_enable_in && power_state_on && !s.hold_act; // R23
	// own pulldown during hold must not count as a new falling edge
	assign pin_fall = s.pin_prev && !rail_enable_in && !s.hold_act; // R13
	assign tmo_hit = s.tmo_act && tmo_ms != 24'h0 && 24'(s.tmo_cnt) >= tmo_ms
		&& !(vout_above_uv || oc_limit_hit); // R05
	assign fault_now = fault_shutdown || (tmo_hit && s.regs[3][`RSQ_ACT_SHUTDOWN_BIT])
		|| (vin_ov_fault && s.regs[2][`RSQ_ACT_SHUTDOWN_BIT]);
	assign retry_now = fault_shutdown ? fault_retry :
		(tmo_hit ? rsq_retries(s.regs[3]) : rsq_retries(s.regs[2])); // R17
	assign wr_idx = rsq_index(cmd_code);
	assign slew_diff = (s.ref_val < output_setpoint) ? output_setpoint - s.ref_val :
		s.ref_val - output_setpoint;

	always_comb begin
		n = s;
		n.pin_prev = rail_enable_in;
		n.div = tick ? 13'h0 : s.div + 13'h1;
		if (tick) begin
			n.msdiv = tick_ms ? 4'h0 : s.msdiv + 4'h1;
			n.cnt = s.cnt + 24'h1;
		end
		// clear first so that a same-cycle event still sets its flag
		if (cmd_wr && cmd_code == `RSQ_CMD_CLEAR) begin
			n.other_flag = 1'b0;
			n.input_flag = 1'b0;
			n.vin_ov_flag = 1'b0;
			n.timeout_flag = 1'b0;
			n.decay_warn = 1'b0;
		end
		if (cmd_wr && wr_idx != 4'hf) begin
			n.regs[wr_idx] = (wr_idx < 4'(`RSQ_NUM_BYTE_REGS)) ?
				{8'h00, cmd_wdata[7:0]} : cmd_wdata;
		end
		if (rsq_index(cmd_code) != 4'hf) begin
			n.rdata = s.regs[rsq_index(cmd_code)];
		end else if (cmd_code == `RSQ_CMD_STATUS) begin
			n.rdata = 16'h0;
			n.rdata[`RSQ_STS_OTHER] = s.other_flag;
			n.rdata[`RSQ_STS_INPUT] = s.input_flag;
			n.rdata[`RSQ_STS_VIN_OV] = s.vin_ov_flag;
			n.rdata[`RSQ_STS_TIMEOUT] = s.timeout_flag;
			n.rdata[`RSQ_STS_DECAY] = s.decay_warn;
			n.rdata[`RSQ_STS_ON] = s.st != rsq_pkg::RSQ_OFF;
			n.rdata[`RSQ_STS_HOLD] = s.hold_act;
			n.rdata[`RSQ_STS_RETRY] = s.retry_pend;
		end else begin
			n.rdata = 16'h0;
		end
		// forced-low hold on the enable pin
		if (s.hold_act) begin
			if (24'(s.hold_cnt) >= hold_ms) begin
				n.hold_act = 1'b0; // R13
			end else if (tick_ms) begin
				n.hold_cnt = s.hold_cnt + 20'h1; // R13
			end
		end else if (pin_fall) begin
			n.hold_act = 1'b1; // R13
			n.hold_cnt = 20'h0;
		end
		if (s.retry_pend && tick_ms && 24'(s.retry_cnt) < retry_ms) begin
			n.retry_cnt = s.retry_cnt + 20'h1; // R17
		end
		// off-time supervision after the fall ramp
		if (s.decay_act) begin
			if (!vout_above_decay) begin
				n.decay_act = 1'b0; // R11
			end else if (decay_ms != 24'h0 && 24'(s.decay_cnt) >= decay_ms) begin
				n.decay_warn = 1'b1; // R11
				n.decay_act = 1'b0;
			end else if (tick_ms) begin
				n.decay_cnt = s.decay_cnt + 20'h1; // R11
			end
		end
		if (s.tmo_act) begin
			if (vout_above_uv || oc_limit_hit || tmo_hit) begin
				n.tmo_act = 1'b0; // R05
			end else if (tick_ms) begin
				n.tmo_cnt = s.tmo_cnt + 20'h1; // R05
			end
		end
		if (tmo_hit) begin
			n.timeout_flag = 1'b1; // R05
		end
		if (vin_ov_fault) begin
			n.other_flag = 1'b1; // R20
			n.input_flag = 1'b1; // R20
			n.vin_ov_flag = 1'b1; // R20
		end
		unique case (s.st)
			rsq_pkg::RSQ_OFF: begin
				n.ref_val = 12'h0;
				n.hiz = 1'b1;
				if (s.retry_pend) begin
					if (!start_req) begin
						n.retry_pend = 1'b0;
					end else if (24'(s.retry_cnt) >= retry_ms
							&& (decay_wait_en || !vout_above_decay)) begin // R19
						n.retry_pend = 1'b0;
						n.st = rsq_pkg::RSQ_ON_DELAY;
						n.cnt = 24'h0;
					end
				end else if (start_req && !(decay_wait_en && vout_above_decay)) begin // R16
					n.st = rsq_pkg::RSQ_ON_DELAY; // R23
					n.cnt = 24'h0; // R25
				end
			end
			rsq_pkg::RSQ_ON_DELAY: begin
				if (!start_req) begin
					n.st = rsq_pkg::RSQ_OFF;
				end else if (s.cnt >= on_dly) begin // R01
					n.hiz = 1'b0;
					n.cnt = 24'h0;
					n.tmo_act = 1'b1; // R05
					n.tmo_cnt = 20'h0;
					n.decay_act = 1'b0;
					if (rise_bypass) begin
						n.ref_val = output_setpoint; // R04
						n.st = rsq_pkg::RSQ_ON;
					end else begin
						n.st = rsq_pkg::RSQ_RISE;
					end
				end
			end
			rsq_pkg::RSQ_RISE: begin
				n.ref_val = rsq_ramp(output_setpoint, s.cnt, rise_steps); // R02
				if (!start_req) begin
					n.st = rsq_pkg::RSQ_OFF_DELAY;
					n.cnt = 24'h0;
				end else if (s.cnt >= rise_steps) begin
					n.st = rsq_pkg::RSQ_ON;
				end
			end
			rsq_pkg::RSQ_ON: begin
				if (!start_req) begin
					n.st = rsq_pkg::RSQ_OFF_DELAY;
					n.cnt = 24'h0;
				end else if (tick && slew_diff != 12'h0) begin
					if (24'(slew_diff) <= slew_step) begin
						n.ref_val = output_setpoint; // R06
					end else if (s.ref_val < output_setpoint) begin
						n.ref_val = s.ref_val + slew_step[11:0]; // R06
					end else begin
						n.ref_val = s.ref_val - slew_step[11:0]; // R06
					end
				end
			end
			rsq_pkg::RSQ_OFF_DELAY: begin
				if (start_req) begin
					n.st = rsq_pkg::RSQ_ON;
				end else if (s.cnt >= off_dly) begin // R07
					n.st = rsq_pkg::RSQ_FALL;
					n.start_ref = s.ref_val;
					n.cnt = 24'h0;
				end
			end
			rsq_pkg::RSQ_FALL: begin
				n.ref_val = s.start_ref - rsq_ramp(s.start_ref, s.cnt, fall_steps); // R09
				if (s.cnt >= fall_steps) begin
					n.ref_val = 12'h0;
					n.hiz = 1'b1; // R09
					n.st = rsq_pkg::RSQ_OFF;
					n.decay_act = 1'b1; // R11
					n.decay_cnt = 20'h0;
				end
			end
		endcase
		// a fault goes straight to the fall ramp, no off delay
		if (fault_now && s.st != rsq_pkg::RSQ_OFF && s.st != rsq_pkg::RSQ_FALL) begin
			n.st = rsq_pkg::RSQ_FALL; // R08
			n.start_ref = s.ref_val;
			n.cnt = 24'h0;
			n.tmo_act = 1'b0;
			n.retry_pend = retry_now; // R17
			n.retry_cnt = 20'h0; // R17
		end
		n.force_dcm = n.st == rsq_pkg::RSQ_RISE || !ccm_mode; // R03
		n.sink_en = !n.force_dcm && !n.hiz; // R22
		n.uv_mask = n.st != rsq_pkg::RSQ_ON; // R24
		n.chan_on = n.st != rsq_pkg::RSQ_OFF;
		n.alert_n = !((n.other_flag || n.input_flag || n.vin_ov_flag || n.timeout_flag
			|| n.decay_warn) && !alert_mask); // R20
		if (rst) begin
			n = '0;
			n.regs = RESET_REGS;
			n.hiz = 1'b1;
			n.uv_mask = 1'b1;
			n.alert_n = 1'b1;
			n.force_dcm = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= n;
	end

	// open-drain pin: only ever pulled low
	assign rail_enable_out = 1'b0;
	assign rail_enable_oe = s.hold_act;
	assign cmd_rdata = s.rdata;
	assign ref_dac = s.ref_val;
	assign pwm_hiz = s.hiz;
	assign force_dcm = s.force_dcm;
	assign sink_enable = s.sink_en;
	assign uv_mask = s.uv_mask;
	assign channel_on = s.chan_on;
	assign rise_timeout_fault = s.timeout_flag;
	assign decay_warn = s.decay_warn;
	assign alert_n = s.alert_n;
endmodule

// *** src/rsq_consts.svh ***
// constants for the rail on/off sequencer: command codes, resets, limits
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
`define RSQ_CMD_OV_ACT 8'h41
`define RSQ_CMD_UV_ACT 8'h45
`define RSQ_CMD_VIN_ACT 8'h56
`define RSQ_CMD_TMO_ACT 8'h63
`define RSQ_CMD_OFF_DLY 8'h64
`define RSQ_CMD_FALL 8'h65
`define RSQ_CMD_DECAY 8'h66
`define RSQ_CMD_RETRY 8'hdb
`define RSQ_CMD_HOLD 8'hdc
`define RSQ_CMD_ON_DLY 8'h60
`define RSQ_CMD_RISE 8'h61
`define RSQ_CMD_TMO_LIM 8'h62
`define RSQ_CMD_SLEW 8'h27
`define RSQ_CMD_STATUS 8'h79
`define RSQ_CMD_CLEAR 8'h03
`define RSQ_RST_OV_ACT 16'h00b8
`define RSQ_RST_UV_ACT 16'h00b8
`define RSQ_RST_VIN_ACT 16'h0080
`define RSQ_RST_TMO_ACT 16'h00b8
`define RSQ_RST_OFF_DLY 16'h8000
`define RSQ_RST_FALL 16'hd200
`define RSQ_RST_DECAY 16'hf258
`define RSQ_RST_RETRY 16'hfabc
`define RSQ_RST_HOLD 16'hfbe8
`define RSQ_RST_ON_DLY 16'h8000
`define RSQ_RST_RISE 16'hd200
`define RSQ_RST_TMO_LIM 16'hd280
`define RSQ_RST_SLEW 16'haa00
`define RSQ_NUM_REGS 13
`define RSQ_NUM_BYTE_REGS 4
`define RSQ_CLK_MHZ 50
`define RSQ_TICK_US 100
`define RSQ_TICK_CYCLES (`RSQ_TICK_US * `RSQ_CLK_MHZ)
`define RSQ_TICKS_PER_MS 10
`define RSQ_ZERO_LAT_US 270
`define RSQ_ZERO_LAT_TICKS ((`RSQ_ZERO_LAT_US + `RSQ_TICK_US - 1) / `RSQ_TICK_US)
`define RSQ_DELAY_MAX_S 83
`define RSQ_DELAY_MAX_MS (`RSQ_DELAY_MAX_S * 1000)
`define RSQ_RISE_BYPASS_CENTI_MS 25
`define RSQ_FALL_MIN_STEPS 3
`define RSQ_RAMP_MAX_MS 1300
`define RSQ_DECAY_MIN_MS 120
`define RSQ_DECAY_MAX_MS 524000
`define RSQ_HOLD_MIN_MS 136
`define RSQ_HOLD_MAX_MS 65520
`define RSQ_HOLD_RES_MS 16
`define RSQ_RETRY_MIN_MS 120
`define RSQ_RETRY_MAX_MS 83880
`define RSQ_SLEW_MAX_V_PER_MS 4
`define RSQ_ACT_SHUTDOWN_BIT 7
`define RSQ_ACT_RETRY_MSB 5
`define RSQ_ACT_RETRY_LSB 3
`define RSQ_ACT_RETRY_ALWAYS 3'h7
`define RSQ_STS_OTHER 0
`define RSQ_STS_INPUT 1
`define RSQ_STS_VIN_OV 2
`define RSQ_STS_TIMEOUT 3
`define RSQ_STS_DECAY 4
`define RSQ_STS_ON 5
`define RSQ_STS_HOLD 6
`define RSQ_STS_RETRY 7
`endif

// *** src/rsq_pkg.sv ***
// types of the rail on/off sequencer
package rsq_pkg;
	typedef enum logic [2:0] {
		RSQ_OFF,
		RSQ_ON_DELAY,
		RSQ_RISE,
		RSQ_ON,
		RSQ_OFF_DELAY,
		RSQ_FALL
	} rsq_phase_type;

	typedef struct packed {
		rsq_phase_type st;
		logic chan_on;
		logic [12:0][15:0] regs;
		logic [12:0] div;
		logic [3:0] msdiv;
		logic [23:0] cnt;
		logic [11:0] ref_val;
		logic [11:0] start_ref;
		logic [19:0] hold_cnt;
		logic hold_act;
		logic [19:0] retry_cnt;
		logic retry_pend;
		logic [19:0] decay_cnt;
		logic decay_act;
		logic [19:0] tmo_cnt;
		logic tmo_act;
		logic pin_prev;
		logic other_flag;
		logic input_flag;
		logic vin_ov_flag;
		logic timeout_flag;
		logic decay_warn;
		logic [15:0] rdata;
		logic hiz;
		logic force_dcm;
		logic sink_en;
		logic uv_mask;
		logic alert_n;
	} rsq_state_type;
endpackage

// *** testbench/rsq_checker.sv ***
// assertion checker bound to the rail sequencer ports
`timescale 1ns/100ps
module rsq_checker #(
	parameter int TICK_CYCLES = 5000,
	parameter int DAC_CODES_PER_V = 500
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ccm_mode,
	input wire logic rail_enable_in,
	input wire logic rail_enable_out,
	input wire logic rail_enable_oe,
	input wire logic vin_ov_fault,
	input wire logic alert_mask,
	input wire logic [11:0] ref_dac,
	input wire logic pwm_hiz,
	input wire logic force_dcm,
	input wire logic sink_enable,
	input wire logic uv_mask,
	input wire logic channel_on,
	input wire logic alert_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_on_wait;
		$rose(channel_on) |-> pwm_hiz [*8];
	endproperty
	a_on_wait: assert property (p_on_wait) else $error("switching without on delay");
	property p_dcm_rise;
		$fell(pwm_hiz) |-> force_dcm;
	endproperty
	a_dcm_rise: assert property (p_dcm_rise) else $error("rise not in dcm");
	property p_no_sink;
		!ccm_mode |=> !sink_enable;
	endproperty
	a_no_sink: assert property (p_no_sink) else $error("sinking in dcm");
	property p_hiz_zero;
		$rose(pwm_hiz) |-> ref_dac == 12'h000;
	endproperty
	a_hiz_zero: assert property (p_hiz_zero) else $error("released above zero");
	property p_off_masked;
		!channel_on |-> uv_mask;
	endproperty
	a_off_masked: assert property (p_off_masked) else $error("uv unmasked while off");
	property p_unmask_on;
		!uv_mask |-> channel_on && !pwm_hiz;
	endproperty
	a_unmask_on: assert property (p_unmask_on) else $error("uv unmasked not on");
	property p_hold_edge;
		$fell(rail_enable_in) |-> ##[1:2] rail_enable_oe;
	endproperty
	a_hold_edge: assert property (p_hold_edge) else $error("pin not held");
	property p_pull_low;
		rail_enable_oe |-> !rail_enable_out;
	endproperty
	a_pull_low: assert property (p_pull_low) else $error("pin driven high");
	property p_alert;
		vin_ov_fault && !alert_mask |-> ##[1:2] !alert_n;
	endproperty
	a_alert: assert property (p_alert) else $error("no alert on vin ov");
endmodule

bind rsq_sequencer rsq_checker #(.TICK_CYCLES(TICK_CYCLES), .DAC_CODES_PER_V(DAC_CODES_PER_V))
	rsq_checker_inst (.clk_sys, .rst, .ccm_mode, .rail_enable_in, .rail_enable_out,
	.rail_enable_oe, .vin_ov_fault, .alert_mask, .ref_dac, .pwm_hiz, .force_dcm, .sink_enable,
	.uv_mask, .channel_on, .alert_n);

// *** testbench/rsq_rail_model.sv ***
// far side model: enable pin wire and the output rail
`timescale 1ns/100ps
module rsq_rail_model #(
	parameter int DECAY_CYC = 16000
) (
	input wire logic clk_sys,
	input wire logic ext_enable,
	input wire logic rail_enable_out,
	input wire logic rail_enable_oe,
	input wire logic [11:0] ref_dac,
	input wire logic pwm_hiz,
	input wire logic [11:0] output_setpoint,
	output logic rail_enable_in,
	output logic vout_above_uv,
	output logic vout_above_decay
);
	int dcnt = 0;
	// pulled up, either side may pull low
	assign rail_enable_in = ext_enable && !(rail_enable_oe && !rail_enable_out);
	assign vout_above_uv = !pwm_hiz && ref_dac >= (output_setpoint >> 1);
	// charge bleeds slowly once released
	always @(posedge clk_sys) begin
		if (!pwm_hiz)
			dcnt <= DECAY_CYC;
		else if (dcnt > 0)
			dcnt <= dcnt - 1;
	end
	assign vout_above_decay = (!pwm_hiz && ref_dac > (output_setpoint >> 3)) || dcnt > 0;
endmodule

// *** testbench/test_rsq_sequencer.sv ***
// self-checking bench for the rail on/off sequencer
`timescale 1ns/100ps
module test_rsq_sequencer;
	localparam int TICK = 10;
	localparam int MS = TICK * 10;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cmd_wr = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic power_state_on = 1'b0;
	logic ext_enable = 1'b0;
	logic [11:0] output_setpoint = 12'h100;
	logic ccm_mode = 1'b1;
	logic decay_wait_en = 1'b0;
	logic oc_limit_hit = 1'b0;
	logic fault_shutdown = 1'b0;
	logic fault_retry = 1'b1;
	logic vin_ov_fault = 1'b0;
	logic alert_mask = 1'b1;
	logic [15:0] cmd_rdata, v;
	logic [11:0] ref_dac;
	logic rail_enable_in, rail_enable_out, rail_enable_oe, vout_above_uv, vout_above_decay;
	logic pwm_hiz, force_dcm, sink_enable, uv_mask, channel_on, rise_timeout_fault;
	logic decay_warn, alert_n;
	int fails = 0;
	int n_compared = 0;
	int n, m;
	logic [7:0] codes [9] = '{8'h41, 8'h45, 8'h56, 8'h63, 8'h64, 8'h65, 8'h66, 8'hdb, 8'hdc};
	logic [15:0] rstv [9] = '{16'h00b8, 16'h00b8, 16'h0080, 16'h00b8, 16'h8000, 16'hd200,
		16'hf258, 16'hfabc, 16'hfbe8};

	always #10 clk_sys = ~clk_sys;

	rsq_sequencer #(.TICK_CYCLES(TICK)) rsq_sequencer_inst (.clk_sys, .rst, .cmd_code, .cmd_wr,
		.cmd_wdata, .cmd_rdata, .power_state_on, .rail_enable_in, .rail_enable_out,
		.rail_enable_oe, .output_setpoint, .ccm_mode, .decay_wait_en, .vout_above_uv,
		.oc_limit_hit, .vout_above_decay, .fault_shutdown, .fault_retry, .vin_ov_fault,
		.alert_mask, .ref_dac, .pwm_hiz, .force_dcm, .sink_enable, .uv_mask, .channel_on,
		.rise_timeout_fault, .decay_warn, .alert_n);
	rsq_rail_model rsq_rail_model_inst (.clk_sys, .ext_enable, .rail_enable_out, .rail_enable_oe,
		.ref_dac, .pwm_hiz, .output_setpoint, .rail_enable_in, .vout_above_uv, .vout_above_decay);

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_dur(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			fails++;
			$display("[FAIL] %0t took %0d cycles, expected %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_sys);
		cmd_code <= c;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge clk_sys);
		cmd_code <= c;
		@(posedge clk_sys);
		#1 d = cmd_rdata;
	endtask
	task automatic skip(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return pwm_hiz;
			1: return uv_mask;
			2: return rail_enable_oe;
			3: return channel_on;
			default: return ref_dac != output_setpoint;
		endcase
	endfunction
	// bounded wait, count of cycles until the level shows
	task automatic wait_sig(input int w, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys);
			#1 cnt++;
		end while (sig(w) !== lvl && cnt < lim);
	endtask

	initial begin
		#2000000;
		$display("[FAIL] %0t watchdog expired", $time);
		fails++;
		results;
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			rd(codes[i], v);
			chk16(v, rstv[i]);
		end
		rd(8'h00, v);
		chk16(v, 16'h0000);
		wr(8'h56, 16'h12b8);
		rd(8'h56, v);
		chk16(v, 16'h00b8);
		wr(8'h60, 16'h0001);
		wr(8'h61, 16'h0001);
		wr(8'h64, 16'h0002);
		wr(8'h65, 16'h8000);
		wr(8'h66, 16'h0078);
		wr(8'hdb, 16'h0078);
		wr(8'hdc, 16'h0090);
		rd(8'h64, v);
		chk16(v, 16'h0002);
		@(posedge clk_sys);
		ext_enable <= 1'b1;
		power_state_on <= 1'b1;
		wait_sig(0, 1'b0, 400, n);
		chk_dur(n, MS - TICK, MS + 2 * TICK);
		chk16({15'h0, force_dcm}, 16'h0001);
		wait_sig(1, 1'b0, 400, n);
		chk_dur(n, MS - TICK, MS + 2 * TICK);
		chk16({4'h0, ref_dac}, 16'h0100);
		chk16({14'h0, force_dcm, sink_enable}, 16'h0001);
		// slow slew so a jump would show
		wr(8'h27, 16'h0001);
		@(posedge clk_sys);
		output_setpoint <= 12'h180;
		skip(3);
		chk16({15'h0, ref_dac < 12'h180}, 16'h0001);
		skip(60);
		chk16({4'h0, ref_dac}, 16'h0180);
		@(posedge clk_sys);
		power_state_on <= 1'b0;
		wait_sig(4, 1'b1, 400, n);
		chk_dur(n, 2 * MS - TICK, 2 * MS + 3 * TICK);
		wait_sig(0, 1'b1, 100, n);
		chk_dur(n, TICK, 4 * TICK);
		skip(11700);
		chk16({15'h0, decay_warn}, 16'h0000);
		skip(600);
		chk16({15'h0, decay_warn}, 16'h0001);
		wr(8'h03, 16'h0000);
		@(posedge clk_sys);
		power_state_on <= 1'b1;
		wait_sig(1, 1'b0, 600, n);
		@(posedge clk_sys);
		fault_shutdown <= 1'b1;
		@(posedge clk_sys);
		fault_shutdown <= 1'b0;
		wait_sig(4, 1'b1, 100, n);
		chk_dur(n, 1, 2 * TICK);
		wait_sig(3, 1'b0, 200, m);
		wait_sig(3, 1'b1, 20000, n);
		chk_dur(m + n, 160 * MS - 100, 160 * MS + 300);
		wait_sig(1, 1'b0, 600, n);
		@(posedge clk_sys);
		decay_wait_en <= 1'b1;
		ccm_mode <= 1'b0;
		ext_enable <= 1'b0;
		wait_sig(2, 1'b1, 10, n);
		chk_dur(n, 1, 3);
		@(posedge clk_sys);
		ext_enable <= 1'b1;
		wait_sig(2, 1'b0, 20000, n);
		chk_dur(n, 143 * MS, 145 * MS);
		skip(1000);
		chk16({15'h0, channel_on}, 16'h0000);
		wait_sig(1, 1'b0, 3000, n);
		chk16({14'h0, force_dcm, sink_enable}, 16'h0002);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			alert_mask <= (k == 0);
			vin_ov_fault <= 1'b1;
			@(posedge clk_sys);
			vin_ov_fault <= 1'b0;
			rd(8'h79, v);
			chk16(v & 16'h0007, 16'h0007);
			chk16({15'h0, alert_n}, {15'h0, k == 0});
			wr(8'h03, 16'h0000);
		end
		rd(8'h79, v);
		chk16(v & 16'h0007, 16'h0000);
		// long rise against a short limit, so the output never gets up in time
		@(posedge clk_sys);
		power_state_on <= 1'b0;
		decay_wait_en <= 1'b0;
		wait_sig(3, 1'b0, 400, n);
		wr(8'h61, 16'h0032);
		wr(8'h62, 16'h0005);
		@(posedge clk_sys);
		power_state_on <= 1'b1;
		wait_sig(0, 1'b0, 400, n);
		skip(4 * MS);
		chk16({15'h0, rise_timeout_fault}, 16'h0000);
		skip(2 * MS);
		chk16({15'h0, rise_timeout_fault}, 16'h0001);
		// zero rise time jumps straight to the setpoint
		@(posedge clk_sys);
		power_state_on <= 1'b0;
		wr(8'h61, 16'h0000);
		wait_sig(3, 1'b0, 400, n);
		@(posedge clk_sys);
		power_state_on <= 1'b1;
		wait_sig(0, 1'b0, 400, n);
		chk16({3'h0, uv_mask, ref_dac}, 16'h0180);
		results;
	end
endmodule
